// ---- design/dsmr_pkg.sv ----
package dsmr_pkg;

  // register numbers as seen by the master (one-based)
  localparam logic [15:0] REG_LEGACY_STATUS = 16'h0006;
  localparam logic [15:0] REG_EXT_STATUS = 16'h07D1;
  localparam logic [15:0] REG_SPEED = 16'h07D2;
  localparam logic [15:0] REG_CURRENT = 16'h07D3;
  localparam logic [15:0] REG_POWER = 16'h07D4;
  localparam logic [15:0] REG_IO_STATUS = 16'h07D5;
  localparam logic [15:0] REG_TORQUE = 16'h07D6;
  localparam logic [15:0] REG_DC_LINK = 16'h07D7;
  localparam logic [15:0] REG_HEATSINK = 16'h07D8;
  localparam logic [15:0] REG_AIN_ONE = 16'h07D9;
  localparam logic [15:0] REG_AIN_TWO = 16'h07DA;
  localparam logic [15:0] REG_AOUT = 16'h07DB;
  localparam logic [15:0] REG_LOOP_OUT = 16'h07DC;
  localparam logic [15:0] REG_BOARD_TEMP = 16'h07DD;
  localparam logic [15:0] REG_OUT_VOLT = 16'h07DE;
  localparam logic [15:0] REG_POT = 16'h07DF;
  localparam logic [15:0] REG_FAULT_CODE = 16'h07E0;

  // user parameter window
  localparam logic [15:0] PARAM_BASE = 16'h0080;
  localparam logic [15:0] PARAM_FIRST = 16'h0004;
  localparam logic [15:0] PARAM_LAST = 16'h003C;
  localparam int PARAM_COUNT = 61;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [5:0] PARAM_RATED_CURRENT = 6'h08;

  // legacy word bit positions
  localparam int LEG_RUN = 0;
  localparam int LEG_TRIP = 1;
  localparam int LEG_STANDBY = 2;
  localparam int LEG_READY = 6;
  localparam int LEG_CODE_LSB = 8;

  // extended word bit positions
  localparam int EXT_READY = 0;
  localparam int EXT_RUN = 1;
  localparam int EXT_TRIP = 2;
  localparam int EXT_STANDBY = 3;
  localparam int EXT_FIRE = 4;
  localparam int EXT_AT_SPEED = 6;
  localparam int EXT_BELOW_MIN = 7;
  localparam int EXT_OVERLOAD = 8;
  localparam int EXT_MAINS_LOSS = 9;
  localparam int EXT_HEATSINK_HOT = 10;
  localparam int EXT_BOARD_HOT = 11;
  localparam int EXT_FOLDBACK = 12;
  localparam int EXT_REVERSE = 13;
  localparam int EXT_TOGGLE = 15;

  // io word bit positions
  localparam int IO_DIN_LSB = 0;
  localparam int IO_SW_FWD = 6;
  localparam int IO_SW_REV = 7;
  localparam int IO_DOUT = 8;
  localparam int IO_RELAY = 9;
  localparam int IO_AIN_ONE_LOSS = 12;
  localparam int IO_AIN_TWO_LOSS = 13;
  localparam int IO_POT_HALF = 15;

  // thresholds
  localparam logic [15:0] HEATSINK_LIMIT_C = 16'h0055;
  localparam logic [15:0] BOARD_LIMIT_C = 16'h0050;
  localparam logic [15:0] POT_HALF_SCALE = 16'h0800;
  localparam logic [15:0] POT_FULL_SCALE = 16'h1000;

  typedef struct packed {
    logic running;
    logic tripped;
    logic standby;
    logic mains_loss;
    logic fire_mode;
    logic drive_enabled;
    logic foldback;
    logic relay_closed;
    logic dig_out_active;
    logic ain_one_loss;
    logic ain_two_loss;
    logic [7:0] trip_code;
    logic [15:0] speed;
    logic [15:0] speed_setpoint;
    logic [15:0] min_speed;
    logic [15:0] current;
    logic [15:0] power;
    logic [15:0] torque;
    logic [15:0] dc_link;
    logic [15:0] heatsink_c;
    logic [15:0] ain_one;
    logic [15:0] ain_two;
    logic [15:0] aout;
    logic [15:0] loop_out;
    logic [15:0] board_c;
    logic [15:0] out_volt;
    logic [15:0] pot;
  } dsmr_drive_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] num;
    logic [15:0] data;
  } dsmr_req_type;

  typedef struct packed {
    logic valid;
    logic error;
    logic [15:0] data;
  } dsmr_rsp_type;

endpackage

// ---- design/dsmr_regs.sv ----
// Functional notes
// - parameter N lives at register 128+N
// - parameters are readable and writable
// - legacy upper byte carries trip code while tripped
// - legacy low bits: run, trip, standby, ready
// - ready: untripped, enable input high, mains present
// - extended bits 0-3: ready run trip standby
// - extended bit 4: fire mode active
// - extended bit 6: enabled and at setpoint
// - extended bit 7: enabled, below minimum
// - extended bit 8: current above rated
// - extended bit 9: mains loss
// - bits 10/11: heatsink over 85, board 80
// - extended bit 12: switching foldback
// - extended bit 13: negative speed
// - extended bit 15 toggles per read
// - io bits 0-3 mirror digital inputs
// - io bits 6/7: forward, reverse switch
// - io bit 8: digital or analog output
// - io bit 9: relay closed
// - io bits 12/13: current loop lost
// - io bit 15: pot above half scale
// - pot register reports 0 to 4096
`timescale 1ns/100ps
`default_nettype none

module dsmr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // drive state, same clock
  input wire dsmr_pkg::dsmr_drive_type drive,
  // pins, asynchronous
  input wire logic [3:0] din_pins,
  input wire logic sw_fwd_pin,
  input wire logic sw_rev_pin,
  // register access from the frame decoder
  input wire dsmr_pkg::dsmr_req_type req,
  output dsmr_pkg::dsmr_rsp_type rsp,
  // rated current for the drive core
  output logic [15:0] rated_current
);

  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic toggle_q;
  logic [15:0] param_q [0:dsmr_pkg::PARAM_COUNT-1];
  logic [15:0] legacy_word;
  logic [15:0] ext_word;
  logic [15:0] io_word;
  logic hw_enable_input;
  logic ready;
  logic param_hit;
  logic [5:0] param_idx;
  logic [15:0] param_off;
  logic [15:0] rd_word;
  logic rd_hit;

  function automatic logic above(input logic [15:0] value, input logic [15:0] limit);
    above = value > limit;
  endfunction

  // two-stage sync; only stage two is read
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_q <= 6'h00;
      pin_sync_q <= 6'h00;
    end else if (ce) begin
      pin_meta_q <= {sw_rev_pin, sw_fwd_pin, din_pins};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign hw_enable_input = pin_sync_q[0];
  assign ready = !drive.tripped && hw_enable_input && !drive.mains_loss;

  always_comb begin
    legacy_word = 16'h0000;
    legacy_word[dsmr_pkg::LEG_RUN] = drive.running;
    legacy_word[dsmr_pkg::LEG_TRIP] = drive.tripped;
    legacy_word[dsmr_pkg::LEG_STANDBY] = drive.standby;
    legacy_word[dsmr_pkg::LEG_READY] = ready;
    if (drive.tripped) begin
      legacy_word[dsmr_pkg::LEG_CODE_LSB +: 8] = drive.trip_code;
    end
  end

  always_comb begin
    ext_word = 16'h0000;
    ext_word[dsmr_pkg::EXT_READY] = ready;
    ext_word[dsmr_pkg::EXT_RUN] = drive.running;
    ext_word[dsmr_pkg::EXT_TRIP] = drive.tripped;
    ext_word[dsmr_pkg::EXT_STANDBY] = drive.standby;
    ext_word[dsmr_pkg::EXT_FIRE] = drive.fire_mode;
    ext_word[dsmr_pkg::EXT_AT_SPEED] = drive.drive_enabled && (drive.speed == drive.speed_setpoint);
    // signed compare: any reverse speed counts as below a non-negative minimum
    ext_word[dsmr_pkg::EXT_BELOW_MIN] = drive.drive_enabled &&
      ($signed(drive.speed) < $signed(drive.min_speed));
    ext_word[dsmr_pkg::EXT_OVERLOAD] = above(drive.current, rated_current);
    ext_word[dsmr_pkg::EXT_MAINS_LOSS] = drive.mains_loss;
    ext_word[dsmr_pkg::EXT_HEATSINK_HOT] = above(drive.heatsink_c, dsmr_pkg::HEATSINK_LIMIT_C);
    ext_word[dsmr_pkg::EXT_BOARD_HOT] = above(drive.board_c, dsmr_pkg::BOARD_LIMIT_C);
    ext_word[dsmr_pkg::EXT_FOLDBACK] = drive.foldback;
    ext_word[dsmr_pkg::EXT_REVERSE] = drive.speed[15];
    ext_word[dsmr_pkg::EXT_TOGGLE] = toggle_q;
  end

  always_comb begin
    io_word = 16'h0000;
    io_word[dsmr_pkg::IO_DIN_LSB +: 4] = pin_sync_q[3:0];
    io_word[dsmr_pkg::IO_SW_FWD] = pin_sync_q[4];
    io_word[dsmr_pkg::IO_SW_REV] = pin_sync_q[5];
    io_word[dsmr_pkg::IO_DOUT] = drive.dig_out_active || (drive.aout != 16'h0000);
    io_word[dsmr_pkg::IO_RELAY] = drive.relay_closed;
    io_word[dsmr_pkg::IO_AIN_ONE_LOSS] = drive.ain_one_loss;
    io_word[dsmr_pkg::IO_AIN_TWO_LOSS] = drive.ain_two_loss;
    io_word[dsmr_pkg::IO_POT_HALF] = above(drive.pot, dsmr_pkg::POT_HALF_SCALE);
  end

  // parameter window decode
  assign param_off = req.num - dsmr_pkg::PARAM_BASE;
  assign param_hit = (req.num >= dsmr_pkg::PARAM_BASE + dsmr_pkg::PARAM_FIRST) &&
    (req.num <= dsmr_pkg::PARAM_BASE + dsmr_pkg::PARAM_LAST);
  assign param_idx = param_off[5:0];

  always_comb begin
    rd_hit = 1'b1;
    rd_word = 16'h0000;
    if (param_hit) begin
      rd_word = param_q[param_idx];
    end else begin
      case (req.num)
        dsmr_pkg::REG_LEGACY_STATUS: rd_word = legacy_word;
        dsmr_pkg::REG_EXT_STATUS: rd_word = ext_word;
        dsmr_pkg::REG_SPEED: rd_word = drive.speed;
        dsmr_pkg::REG_CURRENT: rd_word = drive.current;
        dsmr_pkg::REG_POWER: rd_word = drive.power;
        dsmr_pkg::REG_IO_STATUS: rd_word = io_word;
        dsmr_pkg::REG_TORQUE: rd_word = drive.torque;
        dsmr_pkg::REG_DC_LINK: rd_word = drive.dc_link;
        dsmr_pkg::REG_HEATSINK: rd_word = drive.heatsink_c;
        dsmr_pkg::REG_AIN_ONE: rd_word = drive.ain_one;
        dsmr_pkg::REG_AIN_TWO: rd_word = drive.ain_two;
        dsmr_pkg::REG_AOUT: rd_word = drive.aout;
        dsmr_pkg::REG_LOOP_OUT: rd_word = drive.loop_out;
        dsmr_pkg::REG_BOARD_TEMP: rd_word = drive.board_c;
        dsmr_pkg::REG_OUT_VOLT: rd_word = drive.out_volt;
        // clamp so a stray sample never leaves the 0..4096 range
        dsmr_pkg::REG_POT: rd_word = above(drive.pot, dsmr_pkg::POT_FULL_SCALE) ?
          dsmr_pkg::POT_FULL_SCALE : drive.pot;
        dsmr_pkg::REG_FAULT_CODE: rd_word = {8'h00, drive.trip_code};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // parameter storage; monitoring registers have no write path
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < dsmr_pkg::PARAM_COUNT; i++) begin
        param_q[i] <= dsmr_pkg::PARAM_RESET;
      end
    end else if (ce && req.wr && param_hit) begin
      param_q[param_idx] <= req.data;
    end
  end

  // live bit flips after each read of the extended word
  always_ff @(posedge clk) begin
    if (rst) begin
      toggle_q <= 1'b0;
    end else if (ce && req.rd && !param_hit && req.num == dsmr_pkg::REG_EXT_STATUS) begin
      toggle_q <= !toggle_q;
    end
  end

  // answer one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp <= '0;
    end else if (ce) begin
      rsp.valid <= req.rd || req.wr;
      rsp.data <= req.rd ? rd_word : 16'h0000;
      // writes outside the parameter window are refused
      rsp.error <= (req.rd && !rd_hit) || (req.wr && !param_hit);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rated_current <= dsmr_pkg::PARAM_RESET;
    end else if (ce) begin
      rated_current <= param_q[dsmr_pkg::PARAM_RATED_CURRENT];
    end
  end

endmodule

`default_nettype wire

// ---- verification/dsmr_regs_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsmr_regs_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // watched ports
  input wire dsmr_pkg::dsmr_drive_type drive,
  input wire logic [3:0] din_pins,
  input wire logic sw_fwd_pin,
  input wire logic sw_rev_pin,
  input wire dsmr_pkg::dsmr_req_type req,
  input wire dsmr_pkg::dsmr_rsp_type rsp,
  input wire logic [15:0] rated_current
);
  logic ext_q, seen_q, last_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(n);
    ce && req.rd && req.num == n;
  endsequence
  sequence s_wr(lo, hi);
    ce && req.wr && !req.rd && req.num >= lo && req.num <= hi;
  endsequence
  // read order is kept here, the response alone cannot tell it
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_q <= 1'b0;
      seen_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      ext_q <= ce && req.rd && req.num == 16'h07D1;
      if (rsp.valid && ext_q) begin
        seen_q <= 1'b1;
        last_q <= rsp.data[15];
      end
    end
  end
  property p_lat; (ce && (req.rd || req.wr)) ##1 ce |-> rsp.valid; endproperty
  property p_prw;
    s_wr(16'h0084, 16'h00BC) ##1 s_rd($past(req.num)) |=> !rsp.error && rsp.data == $past(req.data, 2);
  endproperty
  property p_leg;
    s_rd(16'h0006) |=> rsp.data == {$past(drive.tripped) ? $past(drive.trip_code) : 8'h00, 1'b0,
      !$past(drive.tripped) && $past(din_pins[0], 3) && !$past(drive.mains_loss),
      3'b000, $past(drive.standby), $past(drive.tripped), $past(drive.running)};
  endproperty
  property p_ext;
    s_rd(16'h07D1) |=> rsp.data[14:0] == {1'b0, $past(drive.speed[15]), $past(drive.foldback),
      $past(drive.board_c) > 16'h0050, $past(drive.heatsink_c) > 16'h0055, $past(drive.mains_loss),
      $past(drive.current) > $past(rated_current),
      $past(drive.drive_enabled) && $signed($past(drive.speed)) < $signed($past(drive.min_speed)),
      $past(drive.drive_enabled) && $past(drive.speed) == $past(drive.speed_setpoint), 1'b0,
      $past(drive.fire_mode), $past(drive.standby), $past(drive.tripped), $past(drive.running),
      !$past(drive.tripped) && $past(din_pins[0], 3) && !$past(drive.mains_loss)};
  endproperty
  property p_tog; rsp.valid && ext_q |-> rsp.data[15] == (seen_q && !last_q); endproperty
  property p_io;
    s_rd(16'h07D5) |=> {rsp.data[15:12], rsp.data[9:8]} == {$past(drive.pot) > 16'h0800, 1'b0,
      $past(drive.ain_two_loss), $past(drive.ain_one_loss), $past(drive.relay_closed),
      $past(drive.dig_out_active) || $past(drive.aout) != 16'h0000} && (rsp.data & 16'h0C30) == 16'h0000;
  endproperty
  property p_pot; s_rd(16'h07DF) |=> rsp.data == ($past(drive.pot) > 16'h1000 ? 16'h1000 : $past(drive.pot)); endproperty
  property p_ro; s_wr(16'h07D1, 16'h07E0) |=> rsp.valid && rsp.error; endproperty
  a_lat: assert property (p_lat) else $error("no response");
  a_prw: assert property (p_prw) else $error("parameter readback");
  a_leg: assert property (p_leg) else $error("legacy word");
  a_ext: assert property (p_ext) else $error("extended word");
  a_tog: assert property (p_tog) else $error("toggle bit");
  a_io: assert property (p_io) else $error("io word");
  a_pot: assert property (p_pot) else $error("pot value");
  a_ro: assert property (p_ro) else $error("write accepted");
endmodule
`default_nettype wire

// ---- verification/dsmr_master.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsmr_master (
  // clock
  input wire logic clk,
  // register access
  output var dsmr_pkg::dsmr_req_type req,
  input wire dsmr_pkg::dsmr_rsp_type rsp
);
  initial req = '0;
  // call at a falling edge; addr is zero-based as this master numbers them
  task automatic xfer(input logic rd, input logic wr, input logic [15:0] addr, input logic [15:0] wdat,
      output dsmr_pkg::dsmr_rsp_type got);
    req <= '{rd: rd, wr: wr, num: addr + 16'h0001, data: wdat};
    @(negedge clk);
    got = rsp;
  endtask
  // released lines change pattern instead of keeping the last value
  task automatic idle;
    req <= '{rd: 1'b0, wr: 1'b0, num: ~req.num, data: ~req.data};
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verification/dsmr_regs_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsmr_regs_tb;
  logic clk, rst, ce, sw_fwd_pin, sw_rev_pin;
  logic [3:0] din_pins;
  logic [15:0] rated_current;
  dsmr_pkg::dsmr_drive_type drive;
  dsmr_pkg::dsmr_req_type req;
  dsmr_pkg::dsmr_rsp_type rsp;
  int error_cnt, num_checks, cyc;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  dsmr_regs i_dsmr_regs (.clk(clk), .rst(rst), .ce(ce), .drive(drive), .din_pins(din_pins),
    .sw_fwd_pin(sw_fwd_pin), .sw_rev_pin(sw_rev_pin), .req(req), .rsp(rsp), .rated_current(rated_current));
  dsmr_master i_dsmr_master (.clk(clk), .req(req), .rsp(rsp));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic acc(input logic wr, input logic [15:0] rnum, input logic [15:0] wd, input logic err,
      input logic [15:0] exp);
    dsmr_pkg::dsmr_rsp_type got;
    i_dsmr_master.xfer(!wr, wr, rnum - 16'h0001, wd, got);
    i_dsmr_master.idle;
    chk(got, {1'b1, err, exp});
  endtask
  task automatic t_params;
    dsmr_pkg::dsmr_rsp_type got;
    acc(1'b1, 16'h0084, 16'hA5C3, 1'b0, 16'h0000);
    acc(1'b1, 16'h0088, 16'h0050, 1'b0, 16'h0000);
    i_dsmr_master.xfer(1'b0, 1'b1, 16'h00BB, 16'h5A3C, got);
    chk(got, 18'h20000);
    acc(1'b0, 16'h00BC, 16'h0000, 1'b0, 16'h5A3C);
    acc(1'b0, 16'h0084, 16'h0000, 1'b0, 16'hA5C3);
    chk({2'b00, rated_current}, 18'h00050);
    acc(1'b1, 16'h0083, 16'h1111, 1'b1, 16'h0000);
    acc(1'b1, 16'h00BD, 16'h1111, 1'b1, 16'h0000);
    acc(1'b0, 16'h0083, 16'h0000, 1'b1, 16'h0000);
  endtask
  task automatic t_legacy;
    drive = '{tripped: 1'b1, trip_code: 8'h2A, default: '0};
    din_pins = 4'h1;
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h0006, 16'h0000, 1'b0, 16'h2A02);
    acc(1'b0, 16'h07E0, 16'h0000, 1'b0, 16'h002A);
    drive = '{running: 1'b1, trip_code: 8'h2A, default: '0};
    acc(1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0041);
    drive.mains_loss = 1'b1;
    acc(1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0001);
    drive = '{standby: 1'b1, default: '0};
    din_pins = 4'h0;
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h0006, 16'h0000, 1'b0, 16'h0004);
  endtask
  task automatic t_ext;
    din_pins = 4'h1;
    drive = '{running: 1'b1, fire_mode: 1'b1, drive_enabled: 1'b1, foldback: 1'b1, speed: 16'hFFF0,
      speed_setpoint: 16'hFFF0, current: 16'h0100, heatsink_c: 16'h0056, board_c: 16'h0050, default: '0};
    repeat (3) @(negedge clk);
    acc(1'b1, 16'h07D1, 16'hFFFF, 1'b1, 16'h0000);
    acc(1'b0, 16'h07D1, 16'h0000, 1'b0, 16'h35D3);
    drive = '{tripped: 1'b1, standby: 1'b1, mains_loss: 1'b1, drive_enabled: 1'b1, speed: 16'h0010,
      speed_setpoint: 16'h0011, min_speed: 16'h0020, current: 16'h0050, heatsink_c: 16'h0055,
      board_c: 16'h0051, default: '0};
    acc(1'b0, 16'h07D1, 16'h0000, 1'b0, 16'h8A8C);
    acc(1'b1, 16'h07D3, 16'h1234, 1'b1, 16'h0000);
    acc(1'b0, 16'h07D3, 16'h0000, 1'b0, 16'h0050);
  endtask
  task automatic t_io;
    din_pins = 4'hA;
    sw_fwd_pin = 1'b1;
    drive = '{aout: 16'h0001, relay_closed: 1'b1, ain_one_loss: 1'b1, pot: 16'h0801, default: '0};
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h07D5, 16'h0000, 1'b0, 16'h934A);
    din_pins = 4'h5;
    sw_fwd_pin = 1'b0;
    sw_rev_pin = 1'b1;
    drive = '{dig_out_active: 1'b1, ain_two_loss: 1'b1, pot: 16'h0800, default: '0};
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h07D5, 16'h0000, 1'b0, 16'h2185);
    acc(1'b0, 16'h07DF, 16'h0000, 1'b0, 16'h0800);
    drive.pot = 16'h1000;
    acc(1'b0, 16'h07DF, 16'h0000, 1'b0, 16'h1000);
    drive.pot = 16'h1234;
    acc(1'b0, 16'h07DF, 16'h0000, 1'b0, 16'h1000);
  endtask
  // clock enable low must freeze everything; a mid-run reset must clear state
  task automatic t_reset;
    dsmr_pkg::dsmr_rsp_type got;
    acc(1'b0, 16'h07D1, 16'h0000, 1'b0, 16'h0001);
    ce = 1'b0;
    i_dsmr_master.xfer(1'b0, 1'b1, 16'h0083, 16'h7777, got);
    i_dsmr_master.idle;
    chk(got, 18'h00000);
    ce = 1'b1;
    acc(1'b0, 16'h0084, 16'h0000, 1'b0, 16'hA5C3);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 16'h0084, 16'h0000, 1'b0, 16'h0000);
    chk({2'b00, rated_current}, 18'h00000);
    acc(1'b0, 16'h07D1, 16'h0000, 1'b0, 16'h0001);
  endtask
  task automatic finish_test;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // generous ceiling, the run needs under a hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    drive = '0;
    din_pins = 4'h0;
    sw_fwd_pin = 1'b0;
    sw_rev_pin = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_params;
    t_legacy;
    t_ext;
    t_io;
    t_reset;
    finish_test;
  end
endmodule
bind dsmr_regs dsmr_regs_monitor i_dsmr_regs_monitor (.clk(clk), .rst(rst), .ce(ce), .drive(drive),
  .din_pins(din_pins), .sw_fwd_pin(sw_fwd_pin), .sw_rev_pin(sw_rev_pin), .req(req), .rsp(rsp),
  .rated_current(rated_current));
`default_nettype wire
